// ==== verilog/can_controller_regs.svh ====
// register offsets, field positions, reset values and frame timing counts
`ifndef CAN_CONTROLLER_REGS_SVH
`define CAN_CONTROLLER_REGS_SVH
`define REG_ID       2'h0
`define REG_LFD      2'h1
`define REG_PLO      2'h2
`define REG_PHI      2'h3
`define BIT_EXT      31
`define BIT_RTR      30
`define BIT_RTS      8
`define DIV_LSB      16
`define DIV_MSB      25
`define DIV_RESET    10'h3E7
`define IDLE_BITS    4'hB
`define CRC_POLY     15'h4599
`define CRC_BITS     7'h0F
`define TAIL_BITS    7'h0A
`define ACK_LEFT     7'h09
`define ARB_STD      7'h0D
`define ARB_EXT      7'h21
`define HDR_STD      7'h13
`define HDR_EXT      7'h27
`define STUFF_RUN    3'h5
`define MAX_BYTES    4'h8
`endif

// ==== verilog/can_controller_pkg.sv ====
// types shared by the controller and its receiver core
package can_controller_pkg;
	typedef struct packed {
		logic sof;
		logic id_done;
		logic stuff_err;
		logic crc_err;
		logic frame_ok;
	} rx_event_t;
	typedef struct packed {
		logic        ext;
		logic        rtr;
		logic [28:0] id;
		logic [3:0]  dlc;
		logic [31:0] payload_low_word;
		logic [31:0] payload_high_word;
	} rx_frame_t;
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CRC, TX_TAIL} tx_state_t;
endpackage : can_controller_pkg

// ==== verilog/can_controller.sv ====
// register file, receiver flags and frame transmitter of the can controller
// How it works
// - two-bit select, separate write and read registers except the send request bit
// - payload registers byte-addressable, little-endian
// - bit 31 picks extended or standard
// - remote request frames carry no payload
// - extended id 28:0, standard id 10:0
// - identifier read clears receiver flags 4-7
// - bits 3:0 hold length code
// - stuffing flag set, cleared by read/start
// - checksum flag holds until identifier read
// - frame-available only for clean frames
// - overwrite on new identifier while available
// - send request bit self-clears at end
// - lost arbitration aborts, sets flag 9
// - later mismatch in data or checksum aborts, sets flag 10
// - acknowledge seen sets flag 11
// - bit time equals clock times divider+1
// - receive, error and transmit interrupts
// - mute receiver after winning, suppress flags
// - eleven recessive bits start pending frame
`include "can_controller_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module can_controller
	import can_controller_pkg::*;
#(
	parameter int BAUD_W = 10
)(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	// register port
	input  wire logic        cs_i,
	input  wire logic [1:0]  register_select_i,
	input  wire logic [3:0]  byte_sel_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] rdata_o,
	// receiver core
	input  wire rx_event_t   rx_event_i,
	input  wire rx_frame_t   rx_frame_i,
	output logic             rx_mute_o,
	// interrupts
	output logic             irq_rx_o,
	output logic             irq_rxerr_o,
	output logic             irq_tx_o,
	// bus
	input  wire logic        can_rx_i,
	output logic             can_tx_o
);
	if (BAUD_W < 1 || BAUD_W > 10)
	begin : g_bad_width
		$error("BAUD_W must lie in 1..10");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
		return {c[13:0], 1'b0} ^ ((b ^ c[14]) ? `CRC_POLY : 15'h0000);
	endfunction : crc_step

	// write-side registers
	logic [31:0]       tx_id_q, tx_d0_q, tx_d1_q;
	logic [3:0]        tx_dlc_q;
	logic [BAUD_W-1:0] div_q;
	// read-side registers
	rx_frame_t         rx_q;
	logic              stuffing_error_flag_q, crc_q, frame_available_flag_q, overwrite_flag_q;
	logic              rts_q, lost_q, biterr_q, ack_q, armed_q;
	// transmitter
	tx_state_t         st_q;
	logic [102:0]      frame_q;
	logic [6:0]        left_q, bitno_q;
	logic [14:0]       crcv_q;
	logic [2:0]        run_q;
	logic              last_q, stuff_en_q, ack_slot_q, rx_prev_q;
	logic [BAUD_W-1:0] cnt_q;
	logic [3:0]        rec_q;

	// register decode
	wire rd       = cs_i && byte_sel_i == 4'h0;
	wire wr       = cs_i && byte_sel_i != 4'h0;
	wire id_rd    = rd && register_select_i == `REG_ID;
	wire wr_id    = wr && register_select_i == `REG_ID;
	wire wr_lfd   = wr && register_select_i == `REG_LFD;
	wire wr_plo   = wr && register_select_i == `REG_PLO;
	wire wr_phi   = wr && register_select_i == `REG_PHI;
	wire rts_set  = wr_lfd && byte_sel_i[1] && wdata_i[`BIT_RTS];
	wire rts_wclr = wr_lfd && byte_sel_i[1] && !wdata_i[`BIT_RTS] && st_q == TX_IDLE;

	// receiver events other than start of frame are ignored once our own frame is past arbitration
	wire ev_sof   = rx_event_i.sof;
	wire ev_id    = rx_event_i.id_done && !rx_mute_o;
	wire ev_stuffing_error_flag  = rx_event_i.stuff_err && !rx_mute_o;
	wire ev_crc   = rx_event_i.crc_err && !rx_mute_o;
	wire ev_ok    = rx_event_i.frame_ok && !rx_mute_o && !ev_stuffing_error_flag && !ev_crc;

	// set wins over the clearing read
	wire stuffing_error_flag_d   = ev_stuffing_error_flag | (stuffing_error_flag_q & ~id_rd & ~ev_sof);
	wire crc_d    = ev_crc | (crc_q & ~id_rd);
	wire frame_available_flag_d  = ev_ok | (frame_available_flag_q & ~id_rd);
	wire overwrite_flag_d   = (ev_id & frame_available_flag_q) | (overwrite_flag_q & ~id_rd);

	// read selection, write and read sides share only the send request bit
	wire [31:0] rd_id  = {rx_q.ext, rx_q.rtr, 1'b0, rx_q.id};
	wire [31:0] rd_lfd = {20'h00000, ack_q, biterr_q, lost_q, rts_q,
		overwrite_flag_q, frame_available_flag_q, crc_q, stuffing_error_flag_q, rx_q.dlc};
	wire [31:0] rd_mux = register_select_i == `REG_ID  ? rd_id :
		register_select_i == `REG_LFD ? rd_lfd :
		register_select_i == `REG_PLO ? rx_q.payload_low_word : rx_q.payload_high_word;

	// frame assembly
	wire        ext      = tx_id_q[`BIT_EXT];
	wire        rtr      = tx_id_q[`BIT_RTR];
	wire [3:0]  nbytes   = rtr ? 4'h0 : (tx_dlc_q > `MAX_BYTES ? `MAX_BYTES : tx_dlc_q);
	wire [63:0] pay      = {tx_d1_q, tx_d0_q};
	logic [63:0] payload;
	for (genvar i = 0; i < 8; i++)
	begin : g_pay
		assign payload[63-8*i -: 8] = pay[8*i +: 8];
	end
	wire [18:0]  hdr_std = {1'b0, tx_id_q[10:0], rtr, 2'b00, tx_dlc_q};
	wire [38:0]  hdr_ext = {1'b0, tx_id_q[28:18], 2'b11, tx_id_q[17:0], rtr, 2'b00, tx_dlc_q};
	wire [102:0] frame   = ext ? {hdr_ext, payload} : {hdr_std, payload, 20'h00000};
	wire [6:0]   flen    = (ext ? `HDR_EXT : `HDR_STD) + {nbytes, 3'b000};
	wire [6:0]   arb_len = ext ? `ARB_EXT : `ARB_STD;

	// bit timing: free running, re-phased only on the recessive edge while idle
	wire bit_end  = cnt_q == div_q;
	wire sample   = cnt_q == (div_q >> 1);
	wire resync   = st_q == TX_IDLE && !rx_prev_q && can_rx_i;
	wire cts      = rec_q == `IDLE_BITS;
	wire in_arb   = st_q == TX_DATA && bitno_q <= arb_len;
	wire do_stuff = stuff_en_q && run_q == `STUFF_RUN;
	wire mismatch = sample && can_tx_o && !can_rx_i;
	wire checked  = st_q == TX_DATA || st_q == TX_CRC;
	wire nxt_bit  = st_q == TX_DATA ? frame_q[102] : st_q == TX_CRC ? crcv_q[14] : 1'b1;

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			tx_id_q  <= 32'h00000000;
			tx_d0_q  <= 32'h00000000;
			tx_d1_q  <= 32'h00000000;
			tx_dlc_q <= 4'h0;
			div_q    <= BAUD_W'(`DIV_RESET);
		end
		else
		begin
			if (wr_id)
				tx_id_q <= merge(tx_id_q, wdata_i, byte_sel_i);
			if (wr_plo)
				tx_d0_q <= merge(tx_d0_q, wdata_i, byte_sel_i);
			if (wr_phi)
				tx_d1_q <= merge(tx_d1_q, wdata_i, byte_sel_i);
			if (wr_lfd && byte_sel_i[0])
				tx_dlc_q <= wdata_i[3:0];
			// byte writes only move part of the field, hence the halfword rule
			if (wr_lfd && byte_sel_i[2] && byte_sel_i[3])
				div_q <= BAUD_W'(wdata_i[`DIV_MSB:`DIV_LSB]);
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			rx_q    <= '0;
			stuffing_error_flag_q  <= 1'b0;
			crc_q   <= 1'b0;
			frame_available_flag_q <= 1'b0;
			overwrite_flag_q  <= 1'b0;
		end
		else
		begin
			stuffing_error_flag_q  <= stuffing_error_flag_d;
			crc_q   <= crc_d;
			frame_available_flag_q <= frame_available_flag_d;
			overwrite_flag_q  <= overwrite_flag_d;
			if (ev_id)
			begin
				rx_q.ext <= rx_frame_i.ext;
				rx_q.rtr <= rx_frame_i.rtr;
				rx_q.id  <= rx_frame_i.id;
			end
			if (ev_ok)
			begin
				rx_q.dlc   <= rx_frame_i.dlc;
				rx_q.payload_low_word <= rx_frame_i.payload_low_word;
				rx_q.payload_high_word <= rx_frame_i.payload_high_word;
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			cnt_q     <= '0;
			rec_q     <= 4'h0;
			rx_prev_q <= 1'b1;
		end
		else
		begin
			rx_prev_q <= can_rx_i;
			cnt_q     <= (bit_end || resync) ? '0 : cnt_q + 1'b1;
			if (st_q != TX_IDLE || (sample && !can_rx_i))
				rec_q <= 4'h0;
			else if (sample && !cts)
				rec_q <= rec_q + 4'h1;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			st_q       <= TX_IDLE;
			frame_q    <= '0;
			left_q     <= 7'h00;
			bitno_q    <= 7'h00;
			crcv_q     <= 15'h0000;
			run_q      <= 3'h0;
			last_q     <= 1'b1;
			stuff_en_q <= 1'b0;
			ack_slot_q <= 1'b0;
			can_tx_o   <= 1'b1;
			rts_q      <= 1'b0;
			lost_q     <= 1'b0;
			biterr_q   <= 1'b0;
			ack_q      <= 1'b0;
			armed_q    <= 1'b0;
		end
		else
		begin
			if (bit_end)
			begin
				case (st_q)
					TX_IDLE:
					begin
						// start of frame goes out on the first boundary after clear-to-send
						if (cts && rts_q)
						begin
							st_q       <= TX_DATA;
							frame_q    <= frame << 1;
							left_q     <= flen - 7'h01;
							bitno_q    <= 7'h01;
							crcv_q     <= crc_step(15'h0000, 1'b0);
							run_q      <= 3'h1;
							last_q     <= 1'b0;
							stuff_en_q <= 1'b1;
							can_tx_o   <= 1'b0;
						end
					end
					TX_DATA, TX_CRC, TX_TAIL:
					begin
						if (do_stuff)
						begin
							can_tx_o <= ~last_q;
							last_q   <= ~last_q;
							run_q    <= 3'h1;
						end
						else
						begin
							can_tx_o   <= nxt_bit;
							last_q     <= nxt_bit;
							run_q      <= (nxt_bit == last_q) ? run_q + 3'h1 : 3'h1;
							left_q     <= left_q - 7'h01;
							ack_slot_q <= st_q == TX_TAIL && left_q == `ACK_LEFT;
							if (st_q == TX_DATA)
							begin
								frame_q <= frame_q << 1;
								crcv_q  <= crc_step(crcv_q, nxt_bit);
								bitno_q <= bitno_q + 7'h01;
							end
							if (st_q == TX_CRC)
								crcv_q <= crcv_q << 1;
							if (st_q == TX_TAIL)
								stuff_en_q <= 1'b0;
							if (left_q == 7'h01)
							begin
								if (st_q == TX_DATA)
								begin
									st_q   <= TX_CRC;
									left_q <= `CRC_BITS;
								end
								else if (st_q == TX_CRC)
								begin
									st_q   <= TX_TAIL;
									left_q <= `TAIL_BITS;
								end
								else
								begin
									st_q  <= TX_IDLE;
									rts_q <= 1'b0;
								end
							end
						end
					end
					default:
						st_q <= TX_IDLE;
				endcase
			end
			if (mismatch && st_q == TX_TAIL && ack_slot_q)
				ack_q <= 1'b1;
			if (mismatch && checked)
			begin
				st_q       <= TX_IDLE;
				can_tx_o   <= 1'b1;
				rts_q      <= 1'b0;
				stuff_en_q <= 1'b0;
				if (in_arb)
					lost_q <= 1'b1;
				else
					biterr_q <= 1'b1;
			end
			if (rts_wclr)
				rts_q <= 1'b0;
			if (rts_set)
			begin
				rts_q    <= 1'b1;
				armed_q  <= 1'b1;
				lost_q   <= 1'b0;
				biterr_q <= 1'b0;
				ack_q    <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			rdata_o     <= 32'h00000000;
			rx_mute_o   <= 1'b0;
			irq_rx_o    <= 1'b0;
			irq_rxerr_o <= 1'b0;
			irq_tx_o    <= 1'b0;
		end
		else
		begin
			rdata_o     <= rd_mux;
			rx_mute_o   <= st_q != TX_IDLE && !in_arb;
			irq_rx_o    <= frame_available_flag_d;
			irq_rxerr_o <= stuffing_error_flag_d | crc_d;
			irq_tx_o    <= armed_q & ~rts_q;
		end
	end
endmodule : can_controller
`default_nettype wire

// ==== verification/can_bus_node.sv ====
// other bus node: wired-and bus line that can be pulled dominant
`timescale 1ns/10ps
`default_nettype none
module can_bus_node (
	// our drive and the other node's request
	input  wire logic tx_i,
	input  wire logic dom_i,
	// resolved line
	output logic      rx_o
);
	// dominant wins; with nobody pulling, the line rests recessive
	assign rx_o = tx_i & ~dom_i;
endmodule : can_bus_node
`default_nettype wire

// ==== verification/can_controller_monitor.sv ====
// concurrent checks on the can controller ports
`timescale 1ns/10ps
`default_nettype none
module can_controller_monitor
	import can_controller_pkg::*;
(
	// clock, reset and register port
	input wire logic        clock_i,
	input wire logic        nrst_i,
	input wire logic        cs_i,
	input wire logic [1:0]  register_select_i,
	input wire logic [3:0]  byte_sel_i,
	input wire logic [31:0] rdata_o,
	// receiver, interrupts and bus
	input wire rx_event_t   rx_event_i,
	input wire logic        rx_mute_o,
	input wire logic        irq_rx_o,
	input wire logic        irq_rxerr_o,
	input wire logic        irq_tx_o,
	input wire logic        can_rx_i,
	input wire logic        can_tx_o
);
	// recessive run length, saturating so long idles stay large
	logic [7:0] idle_q;
	logic [7:0] idle_d;
	assign idle_d = can_rx_i ? idle_q + {7'h00, idle_q != 8'hFF} : 8'h00;
	always_ff @(posedge clock_i)
		idle_q <= nrst_i ? idle_d : 8'h00;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	property p_reset;
		!$past(nrst_i) |-> can_tx_o && !rx_mute_o && !irq_tx_o && !irq_rx_o && !irq_rxerr_o;
	endproperty
	property p_ok;
		rx_event_i.frame_ok && !rx_event_i.stuff_err && !rx_event_i.crc_err && !rx_mute_o
			|-> ##[1:2] irq_rx_o;
	endproperty
	property p_err;
		(rx_event_i.stuff_err || rx_event_i.crc_err) && !rx_mute_o |-> ##[1:2] irq_rxerr_o;
	endproperty
	property p_mute;
		$rose(rx_mute_o) |-> !irq_tx_o;
	endproperty
	property p_abort;
		(can_tx_o && !can_rx_i) [*4] |=> can_tx_o [*4];
	endproperty
	property p_bit;
		$changed(can_tx_o) |=> $stable(can_tx_o) [*3];
	endproperty
	property p_cts;
		$fell(can_tx_o) && idle_q > 8'h18 |-> idle_q > 8'h28;
	endproperty
	property p_clear;
		cs_i && register_select_i == 2'h0 && byte_sel_i == 4'h0 && rx_event_i == 5'h00
			##1 register_select_i == 2'h1 && rx_event_i == 5'h00 |=> rdata_o[7:4] == 4'h0;
	endproperty
	property p_div;
		register_select_i == 2'h1 |=> rdata_o[31:12] == 20'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("state after reset wrong");
	a_ok: assert property (p_ok) else $error("no receive interrupt");
	a_err: assert property (p_err) else $error("no receive error interrupt");
	a_mute: assert property (p_mute) else $error("mute while transmit idle");
	a_abort: assert property (p_abort) else $error("drive after mismatch");
	a_bit: assert property (p_bit) else $error("bit shorter than divider");
	a_cts: assert property (p_cts) else $error("start before bus idle");
	a_clear: assert property (p_clear) else $error("flags kept after id read");
	a_div: assert property (p_div) else $error("divider readable");
	c_mute: cover property ($rose(rx_mute_o));
	c_start: cover property ($fell(can_tx_o) && idle_q > 8'h18);
	c_frame: cover property (rx_event_i.frame_ok);
endmodule : can_controller_monitor
`default_nettype wire

// ==== verification/tb_top.sv ====
// register-level bench for the can controller with one other bus node
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import can_controller_pkg::*;
	logic        clock_i, nrst_i, cs_i, rx_mute_o, irq_rx_o, irq_rxerr_o, irq_tx_o;
	logic        can_rx_i, can_tx_o, dom;
	logic [1:0]  register_select_i;
	logic [3:0]  byte_sel_i;
	logic [31:0] wdata_i, rdata_o;
	rx_event_t   rx_event_i;
	rx_frame_t   rx_frame_i;
	int          error_cnt, tests_run;
	can_controller i_can_controller (.clock_i, .nrst_i, .cs_i, .register_select_i, .byte_sel_i,
		.wdata_i, .rdata_o, .rx_event_i, .rx_frame_i, .rx_mute_o, .irq_rx_o, .irq_rxerr_o,
		.irq_tx_o, .can_rx_i, .can_tx_o);
	can_bus_node i_can_bus_node (.tx_i(can_tx_o), .dom_i(dom), .rx_o(can_rx_i));
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [1:0] rs, input logic [31:0] exp, got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected reg%0d: expected %h seen %h", rs, exp, got);
		end
	endtask : chk
	// bus tasks leave the strobe up; ev and wt drop it, so no signal moves twice per step
	task automatic rd(input logic [1:0] rs, input logic [31:0] m, exp);
		cs_i = 1'b1;
		register_select_i = rs;
		byte_sel_i = 4'h0;
		@(posedge clock_i);
		#1 chk(rs, exp, rdata_o & m);
	endtask : rd
	task automatic wr(input logic [1:0] rs, input logic [3:0] be, input logic [31:0] d);
		cs_i = 1'b1;
		register_select_i = rs;
		byte_sel_i = be;
		wdata_i = d;
		@(posedge clock_i);
		#1;
	endtask : wr
	task automatic ev(input rx_event_t e);
		cs_i = 1'b0;
		rx_event_i = e;
		@(posedge clock_i);
		#1 rx_event_i = 5'h00;
		@(posedge clock_i);
		#1;
	endtask : ev
	task automatic wt(input logic s);
		int i;
		cs_i = 1'b0;
		byte_sel_i = 4'h0;
		for (i = 0; i < 3000 && (s ? irq_tx_o : !can_tx_o) !== 1'b1; i++)
		begin
			@(posedge clock_i);
			#1;
		end
		if (i == 3000)
		begin
			error_cnt++;
			$display("unexpected wait: expected %b seen %b", s, ~s);
			end_of_test;
		end
	endtask : wt
	task automatic send(input int pre, input int len, input logic [31:0] exp);
		wr(2'h1, 4'h3, 32'h0000_0101);
		rd(2'h1, 32'h100, 32'h100);
		wt(1'b0);
		repeat (pre) @(posedge clock_i);
		#1 dom = (len != 0);
		repeat (len) @(posedge clock_i);
		#1 dom = 1'b0;
		wt(1'b1);
		rd(2'h1, 32'hF00, exp);
	endtask : send
	initial
	begin
		nrst_i = 1'b0;
		cs_i = 1'b0;
		register_select_i = 2'h0;
		byte_sel_i = 4'h0;
		wdata_i = 32'h0;
		rx_event_i = 5'h00;
		rx_frame_i = '{1'b1, 1'b0, 29'h0ABC_DEF1, 4'h2, 32'h4433_2211, 32'h8877_6655};
		dom = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		repeat (4) @(posedge clock_i);
		#1 nrst_i = 1'b1;
		rd(2'h1, 32'hFFFF_FFF0, 32'h0);
		wr(2'h1, 4'hC, 32'h0003_0000);
		rd(2'h1, 32'hFFFF_0000, 32'h0);
		$display("test registers done");
		ev(5'h10);
		ev(5'h08);
		ev(5'h01);
		rd(2'h1, 32'hFF, 32'h42);
		rd(2'h2, 32'hFFFF_FFFF, 32'h4433_2211);
		rd(2'h3, 32'hFFFF_FFFF, 32'h8877_6655);
		ev(5'h10);
		ev(5'h08);
		rd(2'h1, 32'hF0, 32'hC0);
		rd(2'h0, 32'hDFFF_FFFF, 32'h8ABC_DEF1);
		rd(2'h1, 32'hF0, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			ev(5'h10);
			ev(i ? 5'h03 : 5'h05);
			rd(2'h1, 32'hF0, i ? 32'h20 : 32'h10);
			ev(5'h10);
			rd(2'h1, 32'hF0, i ? 32'h20 : 32'h00);
			rd(2'h0, 32'hDFFF_FFFF, 32'h8ABC_DEF1);
			rd(2'h1, 32'hF0, 32'h0);
		end
		$display("test receive done");
		wr(2'h0, 4'hF, 32'h0000_0555);
		wr(2'h2, 4'h1, 32'h0000_00A5);
		send(1, 8, 32'h200);
		send(55, 24, 32'h400);
		// id 555, one byte A5: three stuff bits put the ack slot 46 bits after start
		send(183, 4, 32'h800);
		$display("test transmit done");
		end_of_test;
	end
endmodule : tb_top
bind can_controller can_controller_monitor i_can_controller_monitor (.clock_i, .nrst_i, .cs_i,
	.register_select_i, .byte_sel_i, .rdata_o, .rx_event_i, .rx_mute_o, .irq_rx_o, .irq_rxerr_o,
	.irq_tx_o, .can_rx_i, .can_tx_o);
`default_nettype wire
